// File: hw/reader_page_defines.svh
// offsets, bit positions, reset values and timing counts of the control/status page
`ifndef READER_PAGE_DEFINES_SVH
`define READER_PAGE_DEFINES_SVH

// register offsets on the parallel host port
`define RCP_OFF_CONTROL 6'h09
`define RCP_OFF_ERROR 6'h0A
`define RCP_OFF_COLL_POS 6'h0B
`define RCP_OFF_TIMER 6'h0C
`define RCP_OFF_CRC_LOW 6'h0D
`define RCP_OFF_CRC_HIGH 6'h0E

// control register fields
`define CTL_RSV_HI 7
`define CTL_RSV_LO 6
`define CTL_LIGHT_SLEEP_BIT 5
`define CTL_DEEP_SLEEP_BIT 4
`define CTL_TIMER_BIT2 2
`define CTL_TIMER_BIT1 1
`define CTL_FLUSH_BIT 0

// error flag fields
`define ERR_NVM_BIT 5
`define ERR_OVFL_BIT 4
`define ERR_CRC_BIT 3
`define ERR_SOF_BIT 2
`define ERR_COLL_BIT 0

// reset values
`define RCP_RST_CONTROL 8'h00
`define RCP_RST_ERROR 8'h00
`define RCP_RST_COLL_POS 8'h00
`define RCP_RST_READ 8'h00

// oscillator restart wait after deep sleep
`define CLK_PERIOD_NS 100
`define OSC_SETTLE_NS 1000
`define OSC_SETTLE_CYC ((`OSC_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: hw/reader_page_pkg.sv
// types shared by the control/status page modules
package reader_page_pkg;

  typedef enum logic [1:0] {PWR_ACTIVE, PWR_LIGHT, PWR_DEEP, PWR_SETTLE} power_state_t;

  typedef enum logic [2:0] {
    SEL_NONE, SEL_CONTROL, SEL_ERROR, SEL_COLL_POS, SEL_TIMER, SEL_CRC_LOW, SEL_CRC_HIGH
  } reg_sel_t;

endpackage : reader_page_pkg

// File: hw/page_host_decode.sv
// address decode of the page registers on the parallel host port
`timescale 1ns/100ps
`default_nettype none
`include "reader_page_defines.svh"

module page_host_decode (
  input wire logic [5:0] i_addr,
  input wire logic i_wr_stb,
  input wire logic i_clk_en,
  output logic o_wr_control,
  output reader_page_pkg::reg_sel_t o_sel
);
  import reader_page_pkg::*;

  // one select per register, none for unmapped offsets
  assign o_sel = (i_addr == `RCP_OFF_CONTROL) ? SEL_CONTROL :
                 (i_addr == `RCP_OFF_ERROR) ? SEL_ERROR :
                 (i_addr == `RCP_OFF_COLL_POS) ? SEL_COLL_POS :
                 (i_addr == `RCP_OFF_TIMER) ? SEL_TIMER :
                 (i_addr == `RCP_OFF_CRC_LOW) ? SEL_CRC_LOW :
                 (i_addr == `RCP_OFF_CRC_HIGH) ? SEL_CRC_HIGH : SEL_NONE;

  // only the control register takes writes; the rest are read-only
  assign o_wr_control = i_wr_stb & i_clk_en & (o_sel == SEL_CONTROL);

endmodule : page_host_decode
`default_nettype wire

// File: hw/error_flag_bank.sv
// sticky error flags of the last command
`timescale 1ns/100ps
`default_nettype none
`include "reader_page_defines.svh"

module error_flag_bank (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  input wire logic i_nvm_rights_violation,
  input wire logic i_nvm_cmd_start,
  input wire logic i_queue_write_attempt,
  input wire logic i_queue_full,
  input wire logic i_queue_flush,
  input wire logic i_receive_check_enable,
  input wire logic i_checksum_fail,
  input wire logic i_sof_error,
  input wire logic i_collision_detect,
  input wire logic i_receiver_prepare_state,
  output logic [7:0] o_flags
);
  import reader_page_pkg::*;

  localparam int NFLAG = 5;
  localparam int FLAG_POS [NFLAG] = '{`ERR_NVM_BIT, `ERR_OVFL_BIT, `ERR_CRC_BIT,
                                      `ERR_SOF_BIT, `ERR_COLL_BIT};

  logic [NFLAG-1:0] set_v;
  logic [NFLAG-1:0] clr_v;
  logic [NFLAG-1:0] flag_r;
  logic [NFLAG-1:0] flag_nxt;

  // set and clear causes per flag
  assign set_v[0] = i_nvm_rights_violation;
  assign clr_v[0] = i_nvm_cmd_start;
  assign set_v[1] = i_queue_write_attempt & i_queue_full;
  assign clr_v[1] = i_queue_flush;
  assign set_v[2] = i_receive_check_enable & i_checksum_fail;
  assign clr_v[2] = i_receiver_prepare_state;
  assign set_v[3] = i_sof_error;
  assign clr_v[3] = i_receiver_prepare_state;
  assign set_v[4] = i_collision_detect;
  assign clr_v[4] = i_receiver_prepare_state;

  // set beats clear so a late event is never lost; flags hold otherwise
  generate
    for (genvar g = 0; g < NFLAG; g++)
    begin : g_flag
      assign flag_nxt[g] = set_v[g] | (flag_r[g] & ~clr_v[g]);
      always_ff @(posedge i_sys_clk or negedge i_nrst)
      begin
        if (!i_nrst)
          flag_r[g] <= 1'(`RCP_RST_ERROR >> FLAG_POS[g]);
        else if (i_clk_en)
          flag_r[g] <= flag_nxt[g];
      end
      assign o_flags[FLAG_POS[g]] = flag_r[g];
    end
  endgenerate

  // reserved positions read zero
  assign o_flags[7:6] = 2'h0;
  assign o_flags[1] = 1'b0;

endmodule : error_flag_bank
`default_nettype wire

// File: hw/reader_control_status_page.sv
// control and status register page: power saving, strobes, error flags, results
`timescale 1ns/100ps
`default_nettype none
`include "reader_page_defines.svh"

// Notes on behaviour
// - writing 1 to light-sleep bit stops consuming blocks, oscillator keeps running
// - writing 1 to deep-sleep bit stops consuming blocks and the oscillator
// - control bit 2 acts on the timer at once and reads 0
// - control bit 1 acts on the timer at once and reads 0
// - flush bit empties the queue pointers, clears overflow, reads 0
// - rights violation flag sets on violation, clears at memory command start
// - overflow flag sets on any write attempt into a full queue
// - checksum fail flag sets if checking enabled; clears in receiver preparation
// - start-of-frame error flag sets on bad frame start; clears in preparation
// - bit collision flag sets on collision; clears in receiver preparation
// - collision position holds first collision index; 0 is the start bit
// - timer register shows the live timer count
// - checksum bytes mirror the checksum register, high byte reads 0 for an 8-bit checksum; valid while done flag is 1
// - error register is read-only; bits 7-6 and 1 are reserved
// - checksum done flag reads 1 once calculation has finished

module reader_control_status_page (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  // parallel host port
  input wire logic [5:0] i_addr,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rdata_oe,
  // power saving
  input wire logic i_wake_event,
  output logic o_osc_enable,
  output logic o_blocks_enable,
  output reader_page_pkg::power_state_t o_power_state,
  // strobes to timer and queue
  output logic o_timer_strobe_bit2,
  output logic o_timer_strobe_bit1,
  output logic o_queue_flush_strobe,
  // error sources
  input wire logic i_nvm_rights_violation,
  input wire logic i_nvm_cmd_start,
  input wire logic i_queue_write_attempt,
  input wire logic i_queue_full,
  input wire logic i_receive_check_enable,
  input wire logic i_checksum_fail,
  input wire logic i_sof_error,
  input wire logic i_collision_detect,
  input wire logic [7:0] i_first_collision_index,
  input wire logic i_receiver_prepare_state,
  output logic [7:0] o_error_flags,
  // timer and checksum engines
  input wire logic [7:0] i_timer_count,
  input wire logic [15:0] i_checksum_value,
  input wire logic i_checksum_8bit,
  input wire logic i_checksum_start,
  input wire logic i_checksum_finish,
  output logic o_checksum_done_flag
);
  import reader_page_pkg::*;

  localparam logic [3:0] SETTLE_CYC = 4'(`OSC_SETTLE_CYC);

  reg_sel_t sel;
  logic wr_control;
  logic [7:0] err_flags;

  logic [1:0] ctl_rsv_r;
  logic [1:0] ctl_rsv_nxt;
  logic light_sleep_r;
  logic light_sleep_nxt;
  logic deep_sleep_osc_off_r;
  logic deep_sleep_osc_off_nxt;

  power_state_t power_state_r;
  power_state_t power_state_nxt;
  logic [3:0] settle_cnt_r;
  logic [3:0] settle_cnt_nxt;

  logic [7:0] first_collision_index_r;
  logic capture_collision;

  logic checksum_done_flag_r;

  logic [7:0] control_view;
  logic [7:0] checksum_high_view;
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;
  logic rdata_oe_r;
  logic rd_take;

  // address decode of the host port
  page_host_decode u_decode (
    .i_addr(i_addr),
    .i_wr_stb(i_wr_stb),
    .i_clk_en(i_clk_en),
    .o_wr_control(wr_control),
    .o_sel(sel)
  );

  // sticky flags of the last command; flush clears overflow too
  error_flag_bank u_errors (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_clk_en(i_clk_en),
    .i_nvm_rights_violation(i_nvm_rights_violation),
    .i_nvm_cmd_start(i_nvm_cmd_start),
    .i_queue_write_attempt(i_queue_write_attempt),
    .i_queue_full(i_queue_full),
    .i_queue_flush(o_queue_flush_strobe),
    .i_receive_check_enable(i_receive_check_enable),
    .i_checksum_fail(i_checksum_fail),
    .i_sof_error(i_sof_error),
    .i_collision_detect(i_collision_detect),
    .i_receiver_prepare_state(i_receiver_prepare_state),
    .o_flags(err_flags)
  );

  assign o_error_flags = err_flags;

  // write strobes act in the same cycle as the write, nothing stored
  assign o_timer_strobe_bit2 = wr_control & i_wdata[`CTL_TIMER_BIT2];
  assign o_timer_strobe_bit1 = wr_control & i_wdata[`CTL_TIMER_BIT1];
  assign o_queue_flush_strobe = wr_control & i_wdata[`CTL_FLUSH_BIT];

  // reserved upper bits are plain read/write storage
  assign ctl_rsv_nxt = wr_control ? i_wdata[`CTL_RSV_HI:`CTL_RSV_LO] : ctl_rsv_r;

  // host writes the sleep bits; a wake event clears them in hardware
  assign light_sleep_nxt = wr_control ? i_wdata[`CTL_LIGHT_SLEEP_BIT] :
                           (i_wake_event ? 1'b0 : light_sleep_r);
  assign deep_sleep_osc_off_nxt = wr_control ? i_wdata[`CTL_DEEP_SLEEP_BIT] :
                                  (i_wake_event ? 1'b0 : deep_sleep_osc_off_r);

  // control register storage
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ctl_rsv_r <= 2'(`RCP_RST_CONTROL >> `CTL_RSV_LO);
      light_sleep_r <= 1'(`RCP_RST_CONTROL >> `CTL_LIGHT_SLEEP_BIT);
      deep_sleep_osc_off_r <= 1'(`RCP_RST_CONTROL >> `CTL_DEEP_SLEEP_BIT);
    end
    else if (i_clk_en)
    begin
      ctl_rsv_r <= ctl_rsv_nxt;
      light_sleep_r <= light_sleep_nxt;
      deep_sleep_osc_off_r <= deep_sleep_osc_off_nxt;
    end
  end

  // power state: deep sleep wins over light sleep when both are set
  always_comb
  begin
    power_state_nxt = power_state_r;
    settle_cnt_nxt = settle_cnt_r;
    case (power_state_r)
      PWR_ACTIVE:
      begin
        if (deep_sleep_osc_off_r)
          power_state_nxt = PWR_DEEP;
        else if (light_sleep_r)
          power_state_nxt = PWR_LIGHT;
      end
      PWR_LIGHT:
      begin
        // oscillator stays up, so leaving needs no restart wait
        if (deep_sleep_osc_off_r)
          power_state_nxt = PWR_DEEP;
        else if (!light_sleep_r)
          power_state_nxt = PWR_ACTIVE;
      end
      PWR_DEEP:
      begin
        // oscillator restarts on exit; blocks wait for it to settle
        if (!deep_sleep_osc_off_r)
        begin
          power_state_nxt = PWR_SETTLE;
          settle_cnt_nxt = SETTLE_CYC;
        end
      end
      PWR_SETTLE:
      begin
        if (deep_sleep_osc_off_r)
          power_state_nxt = PWR_DEEP;
        else if (settle_cnt_r <= 4'h1)
        begin
          power_state_nxt = light_sleep_r ? PWR_LIGHT : PWR_ACTIVE;
          settle_cnt_nxt = 4'h0;
        end
        else
          settle_cnt_nxt = settle_cnt_r - 4'h1;
      end
      default:
      begin
        power_state_nxt = PWR_ACTIVE;
        settle_cnt_nxt = 4'h0;
      end
    endcase
  end

  // power state registers
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      power_state_r <= PWR_ACTIVE;
      settle_cnt_r <= 4'h0;
    end
    else if (i_clk_en)
    begin
      power_state_r <= power_state_nxt;
      settle_cnt_r <= settle_cnt_nxt;
    end
  end

  // consuming blocks run only when fully awake; oscillator off only in deep sleep
  assign o_blocks_enable = (power_state_r == PWR_ACTIVE);
  assign o_osc_enable = (power_state_r != PWR_DEEP);
  assign o_power_state = power_state_r;

  // first collision of a frame: later ones leave the index alone
  assign capture_collision = i_collision_detect & ~err_flags[`ERR_COLL_BIT] &
                             ~i_receiver_prepare_state;

  // collision position register
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      first_collision_index_r <= `RCP_RST_COLL_POS;
    else if (i_clk_en && capture_collision)
      first_collision_index_r <= i_first_collision_index;
  end

  // checksum done: finish beats a start in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      checksum_done_flag_r <= 1'b0;
    else if (i_clk_en)
    begin
      if (i_checksum_finish)
        checksum_done_flag_r <= 1'b1;
      else if (i_checksum_start)
        checksum_done_flag_r <= 1'b0;
    end
  end

  assign o_checksum_done_flag = checksum_done_flag_r;

  // read views; strobe bits and bit 3 always read zero
  assign control_view = {ctl_rsv_r, light_sleep_r, deep_sleep_osc_off_r,
                         1'b0, 1'b0, 1'b0, 1'b0};
  // high byte has no meaning for an 8-bit checksum, so it reads zero then
  assign checksum_high_view = i_checksum_8bit ? 8'h00 : i_checksum_value[15:8];

  // read multiplexer; unmapped offsets read zero
  assign rdata_nxt = (sel == SEL_CONTROL) ? control_view :
                     (sel == SEL_ERROR) ? err_flags :
                     (sel == SEL_COLL_POS) ? first_collision_index_r :
                     (sel == SEL_TIMER) ? i_timer_count :
                     (sel == SEL_CRC_LOW) ? i_checksum_value[7:0] :
                     (sel == SEL_CRC_HIGH) ? checksum_high_view : `RCP_RST_READ;

  assign rd_take = i_rd_stb & i_clk_en;

  // read data is captured at the same edge that sees the strobe
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rdata_r <= `RCP_RST_READ;
      rdata_oe_r <= 1'b0;
    end
    else if (i_clk_en)
    begin
      rdata_oe_r <= rd_take;
      if (rd_take)
        rdata_r <= rdata_nxt;
    end
  end

  assign o_rdata = rdata_r;
  assign o_rdata_oe = rdata_oe_r;

endmodule : reader_control_status_page
`default_nettype wire

// File: tb/page_checker_asserts.sv
// port-level assertions for the control/status page
`timescale 1ns/100ps
`default_nettype none
module page_checker
  import reader_page_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  input wire logic [5:0] i_addr,
  input wire logic i_wr_stb,
  input wire logic [7:0] i_wdata,
  input wire logic i_wake_event,
  input wire logic o_osc_enable,
  input wire logic o_blocks_enable,
  input wire reader_page_pkg::power_state_t o_power_state,
  input wire logic o_timer_strobe_bit2,
  input wire logic o_timer_strobe_bit1,
  input wire logic o_queue_flush_strobe,
  input wire logic i_nvm_rights_violation,
  input wire logic i_nvm_cmd_start,
  input wire logic i_queue_write_attempt,
  input wire logic i_queue_full,
  input wire logic i_receive_check_enable,
  input wire logic i_checksum_fail,
  input wire logic i_sof_error,
  input wire logic i_collision_detect,
  input wire logic i_receiver_prepare_state,
  input wire logic [7:0] o_error_flags,
  input wire logic i_checksum_finish,
  input wire logic o_checksum_done_flag
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);
  // a taken write to the control offset
  wire ctl_wr = i_clk_en && i_wr_stb && i_addr == 6'h09;
  // power states as seen at the outputs
  sequence deep_entered;
    o_power_state == PWR_DEEP && !o_osc_enable && !o_blocks_enable;
  endsequence
  sequence light_entered;
    o_power_state == PWR_LIGHT && o_osc_enable && !o_blocks_enable;
  endsequence
  a_flush_strobe_now: assert property (o_queue_flush_strobe == (ctl_wr && i_wdata[0]))
    else $error("flush strobe wrong");
  a_timer_strobes_now: assert property ({o_timer_strobe_bit2, o_timer_strobe_bit1} == ({2{ctl_wr}} & i_wdata[2:1]))
    else $error("timer strobe wrong");
  a_nvm_flag_clear: assert property ((i_clk_en && i_nvm_cmd_start && !i_nvm_rights_violation) |=> !o_error_flags[5])
    else $error("nvm flag not cleared");
  a_overflow_flag_set: assert property ((i_clk_en && i_queue_write_attempt && i_queue_full) |=> o_error_flags[4])
    else $error("overflow flag not set");
  a_crc_flag_gate: assert property ((i_clk_en && i_checksum_fail && !i_receiver_prepare_state) |=> o_error_flags[3] == ($past(i_receive_check_enable) || $past(o_error_flags[3])))
    else $error("checksum flag gating wrong");
  a_coll_flag_set: assert property ((i_clk_en && i_collision_detect) |=> o_error_flags[0])
    else $error("collision flag not set");
  a_prepare_clears_rx: assert property ((i_clk_en && i_receiver_prepare_state && !i_checksum_fail && !i_sof_error && !i_collision_detect) |=> (o_error_flags & 8'h0D) == 8'h00)
    else $error("receiver flags not cleared");
  a_coll_flag_hold: assert property ($fell(o_error_flags[0]) |-> $past(i_clk_en && i_receiver_prepare_state))
    else $error("collision flag dropped");
  a_done_flag_set: assert property ((i_clk_en && i_checksum_finish) |=> o_checksum_done_flag)
    else $error("done flag not set");
  a_deep_sleep_entry: assert property ((ctl_wr && i_wdata[4] && !i_wake_event && o_power_state == PWR_ACTIVE) |-> ##[1:2] deep_entered)
    else $error("deep sleep not entered");
  a_light_sleep_entry: assert property ((ctl_wr && i_wdata[5] && !i_wdata[4] && !i_wake_event && o_power_state == PWR_ACTIVE) |-> ##[1:2] light_entered)
    else $error("light sleep not entered");
endmodule : page_checker
bind reader_control_status_page page_checker chk (.*);
`default_nettype wire

// File: tb/host_cpu_model.sv
// host processor model driving the parallel register port
`timescale 1ns/100ps
`default_nettype none
module host_cpu_model (
  input wire logic i_sys_clk,
  output logic [5:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_wdata,
  input wire logic [7:0] i_rdata,
  input wire logic i_oe
);
  // idle bus shows inverted leftovers so a stale value never looks valid
  initial
  begin
    o_addr = 6'h3F;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'hA5;
  end
  // one request per cycle, taken at the next edge, answer read after it
  task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
    output logic [7:0] q, output logic oe);
    @(posedge i_sys_clk);
    #1;
    o_addr = a;
    o_wdata = d;
    o_wr = w;
    o_rd = !w;
    @(posedge i_sys_clk);
    #1;
    q = i_rdata;
    oe = i_oe;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask : xfer
endmodule : host_cpu_model
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the control/status page
`timescale 1ns/100ps
`default_nettype none
module tb;
  import reader_page_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_clk_en = 1'b1;
  logic i_queue_full = 1'b0, i_receive_check_enable = 1'b0, i_checksum_8bit = 1'b0;
  logic [7:0] i_first_collision_index = 8'h00, i_timer_count = 8'h00;
  logic [15:0] i_checksum_value = 16'h0000;
  logic [9:0] ev = 10'h000;
  wire i_collision_detect = ev[0];
  wire i_sof_error = ev[1];
  wire i_checksum_fail = ev[2];
  wire i_queue_write_attempt = ev[3];
  wire i_nvm_rights_violation = ev[4];
  wire i_nvm_cmd_start = ev[5];
  wire i_receiver_prepare_state = ev[6];
  wire i_wake_event = ev[7];
  wire i_checksum_start = ev[8];
  wire i_checksum_finish = ev[9];
  wire [5:0] i_addr;
  wire i_wr_stb, i_rd_stb;
  wire [7:0] i_wdata, o_rdata, o_error_flags;
  wire o_rdata_oe, o_osc_enable, o_blocks_enable, o_checksum_done_flag;
  wire o_timer_strobe_bit2, o_timer_strobe_bit1, o_queue_flush_strobe;
  power_state_t o_power_state;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [7:0] fx, px, cv;
  logic [9:0] e;
  reader_control_status_page dut (.*);
  host_cpu_model host (.i_sys_clk(i_sys_clk), .o_addr(i_addr), .o_wr(i_wr_stb),
    .o_rd(i_rd_stb), .o_wdata(i_wdata), .i_rdata(o_rdata), .i_oe(o_rdata_oe));
  always #50 i_sys_clk = ~i_sys_clk;
  // expected flags after one event cycle; clears go first since sets win
  function automatic logic [7:0] flag_next(input logic [7:0] f, input logic [9:0] v);
    logic [7:0] n;
    n = v[6] ? (f & 8'hF2) : f;
    n[5] = (n[5] & !v[5]) | v[4];
    n[4] = n[4] | (v[3] & i_queue_full);
    n[3] = n[3] | (v[2] & i_receive_check_enable);
    n[2] = n[2] | v[1];
    n[0] = n[0] | v[0];
    return n;
  endfunction : flag_next
  task automatic chk8(input string n, input logic [7:0] x, input logic [7:0] g);
    samples_checked++;
    if (g !== x)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask : chk8
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic oe;
    host.xfer(1'b1, a, d, q, oe);
  endtask : wr
  task automatic rd(input string n, input logic [5:0] a, input logic [7:0] x);
    logic [7:0] q;
    logic oe;
    host.xfer(1'b0, a, 8'h00, q, oe);
    chk8("read enable", 8'h01, {7'h00, oe});
    chk8(n, x, q);
  endtask : rd
  // one cycle of event pulses from the engines
  task automatic pulse(input logic [9:0] v);
    @(posedge i_sys_clk);
    #1;
    ev = v;
    @(posedge i_sys_clk);
    #1;
    ev = 10'h000;
  endtask : pulse
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  // hang guard, generous over the expected few hundred cycles
  always @(posedge i_sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      stop_test();
    end
  end
  initial
  begin
    void'($urandom(32'hf85d));
    repeat (20) @(posedge i_sys_clk);
    #1;
    i_nrst = 1'b1;
    rd("control", 6'h09, 8'h00);
    rd("error flags", 6'h0A, 8'h00);
    rd("collision pos", 6'h0B, 8'h00);
    rd("unmapped", 6'h20, 8'h00);
    // control readback: strobe bits always read zero, sleep bits left clear
    repeat (6)
    begin
      cv = 8'($urandom) & 8'hCF;
      wr(6'h09, cv);
      rd("control", 6'h09, {cv[7:6], 6'h00});
    end
    // writes are ignored while the clock enable is low
    i_clk_en = 1'b0;
    wr(6'h09, ~cv & 8'hC0);
    i_clk_en = 1'b1;
    rd("control", 6'h09, {cv[7:6], 6'h00});
    wr(6'h09, 8'h01);
    fx = 8'h00;
    px = 8'h00;
    // random engine events, sometimes with a flush in between
    repeat (40)
    begin
      e = 10'($urandom & $urandom & 32'h7F);
      i_queue_full = 1'($urandom);
      i_receive_check_enable = 1'($urandom);
      i_first_collision_index = 8'($urandom);
      if (e[0] && !fx[0] && !e[6])
        px = i_first_collision_index;
      fx = flag_next(fx, e);
      pulse(e);
      rd("error flags", 6'h0A, fx);
      rd("collision pos", 6'h0B, px);
      if ($urandom % 4 == 0)
      begin
        wr(6'h09, 8'h01);
        fx[4] = 1'b0;
      end
    end
    wr(6'h0A, 8'hFF);
    rd("error flags", 6'h0A, fx);
    repeat (4)
    begin
      i_timer_count = 8'($urandom);
      rd("timer", 6'h0C, i_timer_count);
    end
    for (int k = 0; k < 2; k++)
    begin
      i_checksum_8bit = k[0];
      pulse(10'h100);
      chk8("done flag", 8'h00, {7'h00, o_checksum_done_flag});
      i_checksum_value = 16'($urandom);
      pulse(10'h200);
      chk8("done flag", 8'h01, {7'h00, o_checksum_done_flag});
      rd("checksum low", 6'h0D, i_checksum_value[7:0]);
      if (!i_checksum_8bit)
        rd("checksum high", 6'h0E, i_checksum_value[15:8]);
    end
    wr(6'h09, 8'h20);
    repeat (3) @(posedge i_sys_clk);
    chk8("light state", {6'h00, PWR_LIGHT}, {6'h00, o_power_state});
    chk8("light osc", 8'h02, {6'h00, o_osc_enable, o_blocks_enable});
    wr(6'h09, 8'h00);
    repeat (3) @(posedge i_sys_clk);
    chk8("awake blocks", 8'h01, {7'h00, o_blocks_enable});
    wr(6'h09, 8'h10);
    repeat (3) @(posedge i_sys_clk);
    chk8("deep state", {6'h00, PWR_DEEP}, {6'h00, o_power_state});
    chk8("deep osc", 8'h00, {6'h00, o_osc_enable, o_blocks_enable});
    pulse(10'h080);
    repeat (3) @(posedge i_sys_clk);
    chk8("settle state", {6'h00, PWR_SETTLE}, {6'h00, o_power_state});
    chk8("settle osc", 8'h02, {6'h00, o_osc_enable, o_blocks_enable});
    repeat (12) @(posedge i_sys_clk);
    chk8("woken osc", 8'h03, {6'h00, o_osc_enable, o_blocks_enable});
    stop_test();
  end
endmodule : tb
`default_nettype wire
